/* sbn_pixel_port.sv */
// Purpose: Sync/blank gating and delay, extra transfer shift pulse,
//          nibble pixel mode, mode indicator and general control register.
// Assumes: Pins and external clocks are asynchronous and are synchronised.
// Notes:   External clocks are sampled, so edges are seen two cycles late.
//
// How it works
// R1: normal modes pass both syncs through true or complement gating
// R2: control bits 0 and 1 pick sync output polarity, default high
// R3: pass-through mode forwards syncs unchanged, ignoring polarity bits
// R4: sample on video clock fall normally, pass-through clock rise otherwise
// R5: sync and blank are delayed through a pipeline to match pixels
// R6: delayed active sync switches green sync current off regardless of blank
// R7: source should assert syncs only while blank is active
// R8: split enabled, nibble off, flag rising inserts one extra shift pulse
// R9: extra pulse starts within 20 ns and stays high at least 15 ns
// R10: latch-driven flag must fall within half a shift period of blank rising
// R11: split enabled with flag low leaves the shift clock untouched
// R12: flag is not gated by blank; source keeps it low when unwanted
// R13: nibble is bit3 set bit2 clear; split is bit2 set bit3 clear
// R14: in nibble mode flag high picks upper nibbles, low picks lower
// R15: source changes flag only during blank
// R16: frame buffer holds pixels until shift clock and blank both fall
// R17: software never sets nibble and split together
// R18: nibble mode overrides other mux selections and still extracts nibbles
// R19: chosen nibble goes to the low four bits, high four bits zero
// R20: with bits 3 and 2 clear the flag is ignored
// R21: indicator low at reset and in pass-through, else follows bit 7
// R22: control bit 6 selects little or big endian byte order
// R23: bit 5 enables green sync, bit 4 selects the 7.5 IRE pedestal
// R24: writing 2Dh to mux control low bits selects pass-through and resets
// R25: one extra pulse per flag rise, rearmed only after flag returns low
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module sbn_pixel_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Pins from timing source and frame buffer
  input wire logic line_sync_n_i,
  input wire logic frame_sync_n_i,
  input wire logic blank_n_i,
  input wire logic video_timing_clock_i,
  input wire logic passthrough_input_clock_i,
  input wire logic transfer_nibble_flag_i,
  input wire logic [31:0] pixel_bus_in_i,
  // Base shift clock from the internal divider
  input wire logic shift_clock_base_i,
  // Outputs
  output logic line_pulse_out_o,
  output logic frame_pulse_out_o,
  output logic blank_delayed_n_o,
  output logic green_current_out_sync_o,
  output logic pedestal_en_o,
  output logic shift_clock_o,
  output logic mode_indicator_out_o,
  output logic [31:0] pixel_word_o
);
  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [7:0] gen_ctrl_reg, gen_ctrl_next;
  logic [7:0] mux_ctrl_reg, mux_ctrl_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_take, rd_take, sw_reset;
  logic passthrough, nibble_act, split_act;
  logic flag_s2;

  function automatic logic [3:0] word_addr(input logic [31:0] a);
    word_addr = a[3:0];
  endfunction

  assign passthrough = (mux_ctrl_reg[5:0] == sbn_pkg::PASSTHROUGH_CODE);
  assign nibble_act = gen_ctrl_reg[sbn_pkg::NIBBLE_BIT] & ~gen_ctrl_reg[sbn_pkg::SPLIT_BIT]; // R13
  assign split_act = gen_ctrl_reg[sbn_pkg::SPLIT_BIT] & ~gen_ctrl_reg[sbn_pkg::NIBBLE_BIT]; // R13

  // Both address and data are taken together; a lone one waits
  assign wr_take = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_reg;
  assign rd_take = s_axi_arvalid_i & ~rvalid_reg;
  assign s_axi_awready_o = wr_take;
  assign s_axi_wready_o = wr_take;
  assign s_axi_arready_o = rd_take;
  assign sw_reset = wr_take && s_axi_awaddr_i[31:4] == 28'h0 && word_addr(s_axi_awaddr_i) ==
    sbn_pkg::MUX_CTRL_ADDR && s_axi_wstrb_i[0] && s_axi_wdata_i[5:0] == sbn_pkg::PASSTHROUGH_CODE;

  always_comb begin
    gen_ctrl_next = gen_ctrl_reg;
    mux_ctrl_next = mux_ctrl_reg;
    bvalid_next = bvalid_reg & ~s_axi_bready_i;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg & ~s_axi_rready_i;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (wr_take) begin
      bvalid_next = 1'b1;
      bresp_next = sbn_pkg::RESP_OKAY;
      if (word_addr(s_axi_awaddr_i) == sbn_pkg::GEN_CTRL_ADDR) begin
        if (s_axi_wstrb_i[0]) begin
          gen_ctrl_next = s_axi_wdata_i[7:0];
        end
      end else if (word_addr(s_axi_awaddr_i) == sbn_pkg::MUX_CTRL_ADDR) begin
        if (s_axi_wstrb_i[0]) begin
          mux_ctrl_next = s_axi_wdata_i[7:0];
        end
      end else if (word_addr(s_axi_awaddr_i) != sbn_pkg::STATUS_ADDR ||
                   s_axi_awaddr_i[31:4] != 28'h0) begin
        bresp_next = sbn_pkg::RESP_SLVERR;
      end
      if (s_axi_awaddr_i[31:4] != 28'h0) begin
        gen_ctrl_next = gen_ctrl_reg;
        mux_ctrl_next = mux_ctrl_reg;
        bresp_next = sbn_pkg::RESP_SLVERR;
      end
      if (sw_reset) begin
        gen_ctrl_next = sbn_pkg::GEN_CTRL_RESET; // R24
      end
    end
    if (rd_take) begin
      rvalid_next = 1'b1;
      rresp_next = sbn_pkg::RESP_OKAY;
      rdata_next = 32'h0;
      if (s_axi_araddr_i[31:4] != 28'h0) begin
        rresp_next = sbn_pkg::RESP_SLVERR;
      end else if (word_addr(s_axi_araddr_i) == sbn_pkg::GEN_CTRL_ADDR) begin
        rdata_next[7:0] = gen_ctrl_reg;
      end else if (word_addr(s_axi_araddr_i) == sbn_pkg::MUX_CTRL_ADDR) begin
        rdata_next[7:0] = mux_ctrl_reg;
      end else if (word_addr(s_axi_araddr_i) == sbn_pkg::STATUS_ADDR) begin
        rdata_next[sbn_pkg::ST_PASSTHROUGH_BIT] = passthrough;
        rdata_next[sbn_pkg::ST_NIBBLE_BIT] = nibble_act;
        rdata_next[sbn_pkg::ST_SPLIT_BIT] = split_act;
        rdata_next[sbn_pkg::ST_FLAG_BIT] = flag_s2;
      end else begin
        rresp_next = sbn_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gen_ctrl_reg <= sbn_pkg::GEN_CTRL_RESET; // R2
      mux_ctrl_reg <= sbn_pkg::MUX_CTRL_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg <= sbn_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= sbn_pkg::RESP_OKAY;
      rdata_reg <= 32'h0;
    end else begin
      gen_ctrl_reg <= gen_ctrl_next;
      mux_ctrl_reg <= mux_ctrl_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int PIN_W = 38;
  logic [PIN_W-1:0] pin_raw, pin_s1_reg, pin_s2_reg;
  logic [PIN_W-1:0] pin_prev_reg;
  assign pin_raw = {pixel_bus_in_i, transfer_nibble_flag_i, passthrough_input_clock_i,
                    video_timing_clock_i, blank_n_i, frame_sync_n_i, line_sync_n_i};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1_reg <= {{32{1'b0}}, 3'h0, 3'h7};
      pin_s2_reg <= {{32{1'b0}}, 3'h0, 3'h7};
      pin_prev_reg <= {{32{1'b0}}, 3'h0, 3'h7};
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  logic video_timing_clock_fall, pclk_rise, sample_en, base_prev_reg, pixel_en;
  assign flag_s2 = pin_s2_reg[5];
  assign video_timing_clock_fall = pin_prev_reg[3] & ~pin_s2_reg[3];
  assign pclk_rise = ~pin_prev_reg[4] & pin_s2_reg[4];
  assign sample_en = passthrough ? pclk_rise : video_timing_clock_fall; // R4

  // ****************************************************************
  // Sync and blank path
  // ****************************************************************
  sbn_pipe_if pipe_bus ();
  assign pipe_bus.advance = sample_en; // R5
  assign pipe_bus.flush = sw_reset;
  assign pipe_bus.din = pin_s2_reg[2:0];

  sbn_delay_pipe u_pipe (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .p(pipe_bus.pipe)
  );

  logic line_d_n, frame_d_n, sync_active;
  assign line_d_n = pipe_bus.dout[0];
  assign frame_d_n = pipe_bus.dout[1];
  // Polarity bit set means active high, which inverts the active-low input
  assign line_pulse_out_o = passthrough ? line_d_n :
    (line_d_n ^ gen_ctrl_reg[sbn_pkg::LINE_POL_BIT]); // R1 R2 R3
  assign frame_pulse_out_o = passthrough ? frame_d_n :
    (frame_d_n ^ gen_ctrl_reg[sbn_pkg::FRAME_POL_BIT]); // R1 R2 R3
  assign blank_delayed_n_o = pipe_bus.dout[2];
  // Sync wins over blank; the source is expected to overlap them anyway
  assign sync_active = ~line_d_n | ~frame_d_n; // R6 R7
  assign green_current_out_sync_o = gen_ctrl_reg[sbn_pkg::GREEN_SYNC_BIT] & ~sync_active; // R23
  assign pedestal_en_o = gen_ctrl_reg[sbn_pkg::PEDESTAL_BIT]; // R23
  assign mode_indicator_out_o = ~passthrough & gen_ctrl_reg[sbn_pkg::INDICATOR_BIT]; // R21

  // ****************************************************************
  // Extra shift pulse for split transfers
  // ****************************************************************
  logic armed_reg, armed_next;
  logic [1:0] hold_reg, hold_next;
  logic flag_rise, extra_pulse;
  // Flag is used only in split mode here, so it is ignored otherwise
  assign flag_rise = split_act & armed_reg & flag_s2; // R8 R20 R25

  always_comb begin
    armed_next = armed_reg;
    hold_next = hold_reg;
    if (!flag_s2) begin
      armed_next = 1'b1; // R25
    end else begin
      armed_next = 1'b0;
    end
    if (flag_rise) begin
      hold_next = 2'(sbn_pkg::PULSE_CYCLES - 1); // R9
    end else if (hold_reg != 2'h0) begin
      hold_next = hold_reg - 2'h1;
    end
    if (!split_act || sw_reset) begin
      hold_next = 2'h0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      armed_reg <= 1'b0;
      hold_reg <= 2'h0;
    end else begin
      armed_reg <= armed_next;
      hold_reg <= hold_next;
    end
  end

  // Edge term is combinational so the pulse leaves two cycles after the pin
  assign extra_pulse = split_act & (flag_rise | (hold_reg != 2'h0)); // R8 R9
  assign shift_clock_o = shift_clock_base_i | extra_pulse; // R11 R12

  // ****************************************************************
  // Pixel latch and nibble stage
  // ****************************************************************
  logic [31:0] pix_lat_reg, pix_lat_next, pix_word_reg, pix_word_next, pix_in;
  logic nib_word_reg, nib_word_next;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      base_prev_reg <= 1'b0;
    end else begin
      base_prev_reg <= shift_clock_base_i;
    end
  end
  assign pixel_en = passthrough ? pclk_rise : (shift_clock_base_i & ~base_prev_reg);
  assign pix_in = pin_s2_reg[37:6];

  always_comb begin
    pix_lat_next = pix_lat_reg;
    pix_word_next = pix_word_reg;
    nib_word_next = nib_word_reg;
    if (pixel_en) begin
      pix_lat_next = gen_ctrl_reg[sbn_pkg::BIG_ENDIAN_BIT] ? // R22
        {pix_in[7:0], pix_in[15:8], pix_in[23:16], pix_in[31:24]} : pix_in;
      nib_word_next = nibble_act;
      for (int b = 0; b < 4; b++) begin
        // Nibble mode ignores the mux ratio choice and always extracts
        if (nibble_act) begin
          pix_word_next[8*b +: 8] = {4'h0, flag_s2 ? pix_lat_reg[8*b+4 +: 4] :
            pix_lat_reg[8*b +: 4]}; // R14 R18 R19
        end else begin
          pix_word_next[8*b +: 8] = pix_lat_reg[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pix_lat_reg <= 32'h0;
      pix_word_reg <= 32'h0;
      nib_word_reg <= 1'b0;
    end else begin
      pix_lat_reg <= pix_lat_next;
      pix_word_reg <= pix_word_next;
      nib_word_reg <= nib_word_next;
    end
  end
  assign pixel_word_o = pix_word_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_INDICATOR_PT: assert property (@(posedge clk_i) disable iff (reset_i) // R21
    passthrough |-> !mode_indicator_out_o) else $error("indicator high in pass-through");
  AST_PT_SYNC: assert property (@(posedge clk_i) disable iff (reset_i) // R3
    passthrough |-> (line_pulse_out_o == pipe_bus.dout[0]) && (frame_pulse_out_o ==
    pipe_bus.dout[1])) else $error("pass-through sync changed polarity");
  AST_NORMAL_POL: assert property (@(posedge clk_i) disable iff (reset_i) // R2
    (!passthrough && gen_ctrl_reg[0] && !pipe_bus.dout[0]) |-> line_pulse_out_o)
    else $error("active-high line sync not asserted");
  AST_PULSE_WIDTH: assert property (@(posedge clk_i) disable iff (reset_i) // R9
    ($rose(extra_pulse) && split_act && $stable(split_act)) |-> extra_pulse[*2])
    else $error("extra shift pulse shorter than two cycles");
  AST_PULSE_START: assert property (@(posedge clk_i) disable iff (reset_i) // R8
    (split_act && $rose(pin_s1_reg[5]) && armed_reg) |=> extra_pulse)
    else $error("extra shift pulse late");
  AST_NO_SPLIT: assert property (@(posedge clk_i) disable iff (reset_i) // R11
    !split_act |-> (shift_clock_o == shift_clock_base_i))
    else $error("shift clock altered without split transfer");
  AST_GREEN_OFF: assert property (@(posedge clk_i) disable iff (reset_i) // R6
    (!pipe_bus.dout[0] || !pipe_bus.dout[1]) |-> !green_current_out_sync_o)
    else $error("green sync current on during sync");
  AST_NIBBLE_HI: assert property (@(posedge clk_i) disable iff (reset_i) // R19
    nib_word_reg |-> ((pixel_word_o & 32'hf0f0f0f0) == 32'h0))
    else $error("nibble word high bits not zero");
  AST_SW_RESET: assert property (@(posedge clk_i) disable iff (reset_i) // R24
    sw_reset |=> (gen_ctrl_reg == 8'h03) && passthrough && !mode_indicator_out_o)
    else $error("software reset not applied");
endmodule

/* sbn_pkg.sv */
// Purpose: Shared constants for the sync, blank and nibble pixel port.
// Assumes: 100 MHz system clock; registers reached over AXI4-Lite.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package sbn_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] GEN_CTRL_ADDR = 4'h0;
  localparam logic [3:0] MUX_CTRL_ADDR = 4'h4;
  localparam logic [3:0] STATUS_ADDR = 4'h8;
  localparam logic [7:0] GEN_CTRL_RESET = 8'h03;
  localparam logic [7:0] MUX_CTRL_RESET = 8'h2d;
  localparam logic [5:0] PASSTHROUGH_CODE = 6'h2d;

  // ****************************************************************
  // General control fields
  // ****************************************************************
  localparam int LINE_POL_BIT = 0;
  localparam int FRAME_POL_BIT = 1;
  localparam int SPLIT_BIT = 2;
  localparam int NIBBLE_BIT = 3;
  localparam int PEDESTAL_BIT = 4;
  localparam int GREEN_SYNC_BIT = 5;
  localparam int BIG_ENDIAN_BIT = 6;
  localparam int INDICATOR_BIT = 7;

  // ****************************************************************
  // Status fields
  // ****************************************************************
  localparam int ST_PASSTHROUGH_BIT = 0;
  localparam int ST_NIBBLE_BIT = 1;
  localparam int ST_SPLIT_BIT = 2;
  localparam int ST_FLAG_BIT = 3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_MIN_NS = 15;
  localparam int PULSE_CYCLES = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_MAX_NS = 20;
  localparam int START_CYCLES = START_MAX_NS / CLK_PERIOD_NS;
  localparam int PIPE_DEPTH = 3;
  localparam int SYNC_BITS = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* sbn_pipe_if.sv */
// Purpose: Carrier between the port logic and its sync/blank delay line.
// Assumes: One clock; advance is a one-cycle enable.
// Notes:   Bit 0 line sync, bit 1 frame sync, bit 2 blank, all active low.
`timescale 1ns/10ps
interface sbn_pipe_if;
  logic advance;
  logic flush;
  logic [sbn_pkg::SYNC_BITS-1:0] din;
  logic [sbn_pkg::SYNC_BITS-1:0] dout;
  modport source (output advance, output flush, output din, input dout);
  modport pipe (input advance, input flush, input din, output dout);
endinterface

/* sbn_delay_pipe.sv */
// Purpose: Fixed-depth delay line for sync and blank samples.
// Assumes: Inactive level of all carried signals is high.
// Notes:   Flush returns every stage to the inactive level.
`timescale 1ns/10ps
module sbn_delay_pipe (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Carrier
  sbn_pipe_if.pipe p
);
  logic [sbn_pkg::SYNC_BITS-1:0] stage_reg [sbn_pkg::PIPE_DEPTH];
  logic [sbn_pkg::SYNC_BITS-1:0] stage_next [sbn_pkg::PIPE_DEPTH];

  genvar g;
  generate
    for (g = 0; g < sbn_pkg::PIPE_DEPTH; g++) begin : g_stage
      always_comb begin
        stage_next[g] = stage_reg[g];
        if (p.flush) begin
          stage_next[g] = '1;
        end else if (p.advance) begin
          stage_next[g] = (g == 0) ? p.din : stage_reg[(g == 0) ? 0 : g - 1];
        end
      end
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          stage_reg[g] <= '1;
        end else begin
          stage_reg[g] <= stage_next[g];
        end
      end
    end
  endgenerate

  assign p.dout = stage_reg[sbn_pkg::PIPE_DEPTH-1];
endmodule

/* sbn_far_side.sv */
// Purpose: Far-side model, video timing source and VRAM frame buffer.
// Assumes: Pins change by non-blocking assignment after a rising clk_i.
// Notes:   Timing clocks run free; the shift base runs only on request.
`timescale 1ns/10ps
module sbn_far_side (
  // Clock and returned shift clock
  input wire logic clk_i,
  input wire logic shift_clock_i,
  // Pins toward the port
  output logic line_sync_n_o,
  output logic frame_sync_n_o,
  output logic blank_n_o,
  output logic video_timing_clock_o,
  output logic passthrough_input_clock_o,
  output logic transfer_nibble_flag_o,
  output logic [31:0] pixel_bus_o,
  output logic shift_clock_base_o
);
  logic [2:0] div_reg = 3'h0;
  initial begin
    line_sync_n_o = 1'b1;
    frame_sync_n_o = 1'b1;
    blank_n_o = 1'b1;
    transfer_nibble_flag_o = 1'b0;
    pixel_bus_o = 32'h0;
    shift_clock_base_o = 1'b0;
  end
  always @(posedge clk_i) div_reg <= div_reg + 3'h1;
  assign video_timing_clock_o = div_reg[2];
  assign passthrough_input_clock_o = ~div_reg[2];
  // Blank leads the syncs in and trails them out
  task automatic timing(input logic blank_n, input logic line_n, input logic frame_n);
    @(posedge clk_i);
    blank_n_o <= blank_n_o & blank_n;
    @(posedge clk_i);
    line_sync_n_o <= line_n | blank_n;
    frame_sync_n_o <= frame_n | blank_n;
    @(posedge clk_i);
    blank_n_o <= blank_n;
    transfer_nibble_flag_o <= transfer_nibble_flag_o & ~blank_n;
  endtask
  // Flag moves only inside blanking, since the port does not latch it
  task automatic flag(input logic v);
    @(posedge clk_i);
    transfer_nibble_flag_o <= blank_n_o ? transfer_nibble_flag_o : v;
  endtask
  task automatic pixels(input logic [31:0] d);
    @(posedge clk_i);
    while (shift_clock_i !== 1'b0 || blank_n_o !== 1'b0)
      @(posedge clk_i);
    pixel_bus_o <= d;
  endtask
  task automatic shift(input int n);
    repeat (n) begin
      repeat (2) @(posedge clk_i);
      shift_clock_base_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      shift_clock_base_o <= 1'b0;
    end
  endtask
endmodule

/* sbn_pixel_port_test.sv */
// Purpose: Self-checking bench for the sync, blank and nibble pixel port.
// Assumes: Register map and field positions of sbn_pkg.
// Notes:   Drivers queue expectations; one monitor compares them.
`timescale 1ns/10ps
module sbn_pixel_port_test;
  typedef struct {string name; logic [33:0] val;} sbn_note_type;
  localparam logic [31:0] GEN = {28'h0, sbn_pkg::GEN_CTRL_ADDR};
  localparam logic [31:0] MUX = {28'h0, sbn_pkg::MUX_CTRL_ADDR};
  localparam logic [31:0] STAT = {28'h0, sbn_pkg::STATUS_ADDR};
  localparam logic [1:0] OK = sbn_pkg::RESP_OKAY;
  localparam logic [1:0] BAD = sbn_pkg::RESP_SLVERR;
  logic clk = 1'b0, reset = 1'b1, look = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, pix, word;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lin_n, frm_n, blk_n, video_timing_clock, pclk, flg, base;
  logic lin, frm, blk_d, grn, ped, sck, ind;
  logic [1:0] bresp, rresp, look_sel = 2'h0;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] mode [4] = '{8'h00, 8'h40, 8'h08, 8'h08};
  logic fl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  sbn_note_type notes [$];
  int err_count = 0, compares = 0, pulse_cnt = 0;
  integer seed = 32'heee4e3bb;
  always #5 clk = ~clk;
  sbn_pixel_port u_sbn_pixel_port (.clk_i(clk), .reset_i(reset), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .line_sync_n_i(lin_n), .frame_sync_n_i(frm_n), .blank_n_i(blk_n),
    .video_timing_clock_i(video_timing_clock), .passthrough_input_clock_i(pclk),
    .transfer_nibble_flag_i(flg), .pixel_bus_in_i(pix), .shift_clock_base_i(base),
    .line_pulse_out_o(lin), .frame_pulse_out_o(frm), .blank_delayed_n_o(blk_d),
    .green_current_out_sync_o(grn), .pedestal_en_o(ped), .shift_clock_o(sck),
    .mode_indicator_out_o(ind), .pixel_word_o(word));
  sbn_far_side u_sbn_far_side (.clk_i(clk), .shift_clock_i(sck), .line_sync_n_o(lin_n),
    .frame_sync_n_o(frm_n), .blank_n_o(blk_n), .video_timing_clock_o(video_timing_clock),
    .passthrough_input_clock_o(pclk), .transfer_nibble_flag_o(flg), .pixel_bus_o(pix),
    .shift_clock_base_o(base));
  // ****************************************************************
  // Checking
  // ****************************************************************
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pop(input logic [33:0] seen);
    sbn_note_type n;
    if (notes.size() == 0) begin
      err_count++;
      $display("[ERR] unexpected result %h", seen);
    end else begin
      n = notes.pop_front();
      check(n.name, seen, n.val);
    end
  endtask
  always @(posedge clk) begin
    if (bvalid && bready) pop({bresp, 32'h0});
    if (rvalid && rready) pop({rresp, rdata});
    if (look) pop(look_sel == 2'h0 ? {2'h0, word} : look_sel == 2'h1 ?
      {27'h0, ind, ped, grn, blk_d, frm, lin, sck} : 34'(pulse_cnt));
  end
  always @(negedge clk) if (sck === 1'b1) pulse_cnt++;
  function automatic logic [33:0] pins(input logic i, p, g, b, f, l, s);
    return {27'h0, i, p, g, b, f, l, s};
  endfunction
  function automatic logic [33:0] px(input logic [7:0] m, input logic f, input logic [31:0] d);
    logic [31:0] r;
    r = m[6] ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    for (int b = 0; b < 4; b++)
      if (m[3] && !m[2]) r[8*b +: 8] = {4'h0, f ? r[8*b+4 +: 4] : r[8*b +: 4]};
    return {2'h0, r};
  endfunction
  // ****************************************************************
  // Bus and probe tasks
  // ****************************************************************
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    notes.push_back('{"bresp", {r, 32'h0}});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (awready !== 1'b1 || wready !== 1'b1);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    notes.push_back('{"rdata", e});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic peek(input logic [1:0] sel, input string name, input logic [33:0] e);
    notes.push_back('{name, e});
    @(posedge clk);
    look_sel <= sel;
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #(20000 * 10);
    err_count++;
    test_done();
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(GEN, {OK, 32'h3});
    rd(MUX, {OK, 32'h2d});
    rd(32'hc, {BAD, 32'h0});
    peek(2'h1, "reset pins", pins(0, 0, 0, 1, 1, 1, 0));
    u_sbn_far_side.timing(1'b0, 1'b0, 1'b1);
    repeat (60) @(posedge clk);
    peek(2'h1, "passthrough", pins(0, 0, 0, 0, 1, 0, 0));
    u_sbn_far_side.timing(1'b1, 1'b1, 1'b1);
    $display("test passthrough done");
    wr(MUX, 32'h0, OK);
    for (int p = 0; p < 4; p++) begin
      wr(GEN, {24'h0, 8'hb0 | 8'(p)}, OK);
      u_sbn_far_side.timing(1'b0, 1'b0, 1'b0);
      repeat (60) @(posedge clk);
      peek(2'h1, "sync active", pins(1, 1, 0, 0, p[1], p[0], 0));
      u_sbn_far_side.timing(1'b1, 1'b1, 1'b1);
      repeat (60) @(posedge clk);
      peek(2'h1, "sync idle", pins(1, 1, 1, 1, ~p[1], ~p[0], 0));
    end
    $display("test polarity done");
    wr(GEN, 32'h4, OK);
    rd(STAT, {OK, 32'h4});
    u_sbn_far_side.timing(1'b0, 1'b1, 1'b1);
    pulse_cnt = 0;
    u_sbn_far_side.flag(1'b1);
    repeat (20) @(posedge clk);
    peek(2'h2, "extra pulse", 34'h2);
    u_sbn_far_side.flag(1'b0);
    repeat (10) @(posedge clk);
    u_sbn_far_side.flag(1'b1);
    repeat (20) @(posedge clk);
    peek(2'h2, "rearmed pulse", 34'h4);
    u_sbn_far_side.flag(1'b0);
    repeat (10) @(posedge clk);
    pulse_cnt = 0;
    u_sbn_far_side.shift(3);
    peek(2'h2, "plain shift", 34'h6);
    wr(GEN, 32'h0, OK);
    pulse_cnt = 0;
    u_sbn_far_side.flag(1'b1);
    repeat (20) @(posedge clk);
    peek(2'h2, "flag ignored", 34'h0);
    $display("test split transfer done");
    for (int i = 0; i < 4; i++) begin
      logic [31:0] d;
      d = $random(seed);
      wr(GEN, {24'h0, mode[i]}, OK);
      u_sbn_far_side.flag(fl[i]);
      u_sbn_far_side.pixels(d);
      repeat (4) @(posedge clk);
      u_sbn_far_side.shift(3);
      peek(2'h0, "pixel word", px(mode[i], fl[i], d));
    end
    $display("test pixel path done");
    wr(GEN, 32'hb8, OK);
    wr(MUX, 32'h2d, OK);
    rd(GEN, {OK, 32'h3});
    rd(STAT, {OK, 32'h1});
    wr(GEN, 32'h80, OK);
    repeat (60) @(posedge clk);
    peek(2'h1, "indicator", pins(0, 0, 0, 0, 1, 1, 0));
    wstrb <= 4'he;
    wr(GEN, 32'h33, OK);
    wstrb <= 4'hf;
    wr(32'hc, 32'hff, BAD);
    rd(GEN, {OK, 32'h80});
    $display("test software reset done");
    test_done();
  end
endmodule
